// ===== hdl/twi_pkg.sv
// Summary of operation
// RL1: Device is slave only; master frames transfers.
// RL2: START is data falling while clock high.
// RL3: STOP is data rising while clock high.
// RL4: Data changes only while clock is low.
// RL5: Bus busy from START until STOP.
// RL6: Transmitter releases data; receiver acks ninth clock.
// RL7: No general call, start byte, high speed.
// RL8: First byte is address with write bit.
// RL9: Second byte low five bits load pointer.
// RL10: Device acknowledges every byte written to it.
// RL11: Third byte data stored MSB first.
// RL12: Write burst increments pointer, wraps at end.
// RL13: Master ends writes with STOP or START.
// RL14: Read uses repeated START with read bit.
// RL15: Device sends addressed register MSB first.
// RL16: Missing master ack stops device driving data.
// RL17: Acked read sends next register, wrapping.
// RL18: Master ends reads with nack then STOP.
// RL19: Inputs filter spikes up to 50 ns.
// RL20: Two-wire port active only when selected.
// RL21: Data output held 300 ns after clock falls.
// RL22: Respond only to matching fixed slave address.
package twi_pkg;
    localparam int          REG_COUNT          = 32;
    localparam int          PTR_W              = 5;
    localparam logic [6:0]  SLAVE_ADDR         = 7'h2A;  // Arbitrary value
    localparam int          CLK_PERIOD_NS      = 20;
    localparam int          SPIKE_FILTER_WIDTH_NS = 50;
    localparam int          SPIKE_CYCLES       = (SPIKE_FILTER_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int          HOLD_NS            = 300;
    localparam int          HOLD_CYCLES        = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          HALF_BIT_NS        = 1300;
    localparam int          HALF_BIT_CYCLES    = HALF_BIT_NS / CLK_PERIOD_NS;
endpackage : twi_pkg

// ===== hdl/twi_if.sv
`timescale 1ns/1ns
interface twi_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    // Open drain wired-and with pull-ups
    wire  scl = ~(scl_oe & ~scl_o);
    wire  sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
    modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
    modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface : twi_if

// ===== hdl/twi_slave.sv
`timescale 1ns/1ns
module twi_slave
    import twi_pkg::*;
(
    // System
    input  wire logic        clk,
    input  wire logic        rst,
    // Bus side
    twi_if.slave             bus,
    // Mode select pin
    input  wire logic        twi_sel,
    // Register file access
    output logic             wr_en,
    output logic [PTR_W-1:0] wr_addr,
    output logic [7:0]       wr_data,
    output logic [PTR_W-1:0] rd_addr,
    input  wire logic [7:0]  rd_data,
    output logic             busy
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_DEV = 3'b001, S_ACK = 3'b011, S_PTR = 3'b010,
        S_WDAT = 3'b110, S_RDAT = 3'b111, S_RACK = 3'b101
    } st_e;

    logic [1:0] scl_sy_r, sda_sy_r, sel_sy_r;
    logic       scl_f_r, sda_f_r, scl_f_nxt, sda_f_nxt;
    logic [2:0] scl_cnt_r, sda_cnt_r, scl_cnt_nxt, sda_cnt_nxt;
    always_comb begin
        scl_f_nxt   = scl_f_r;
        sda_f_nxt   = sda_f_r;
        scl_cnt_nxt = 3'h0;
        sda_cnt_nxt = 3'h0;
        // Level must persist past spike width before it is accepted [RL19]
        if (scl_sy_r[1] != scl_f_r) begin
            scl_cnt_nxt = scl_cnt_r + 3'h1;
            if (int'(scl_cnt_r) >= SPIKE_CYCLES - 1) begin
                scl_f_nxt   = scl_sy_r[1];
                scl_cnt_nxt = 3'h0;
            end
        end
        if (sda_sy_r[1] != sda_f_r) begin
            sda_cnt_nxt = sda_cnt_r + 3'h1;
            if (int'(sda_cnt_r) >= SPIKE_CYCLES - 1) begin
                sda_f_nxt   = sda_sy_r[1];
                sda_cnt_nxt = 3'h0;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            scl_sy_r  <= 2'h3;
            sda_sy_r  <= 2'h3;
            sel_sy_r  <= 2'h0;
            scl_f_r   <= 1'b1;
            sda_f_r   <= 1'b1;
            scl_cnt_r <= 3'h0;
            sda_cnt_r <= 3'h0;
        end else begin
            scl_sy_r  <= {scl_sy_r[0], bus.scl};
            sda_sy_r  <= {sda_sy_r[0], bus.sda};
            sel_sy_r  <= {sel_sy_r[0], twi_sel};
            scl_f_r   <= scl_f_nxt;
            sda_f_r   <= sda_f_nxt;
            scl_cnt_r <= scl_cnt_nxt;
            sda_cnt_r <= sda_cnt_nxt;
        end
    end

    logic scl_d_r, sda_d_r;
    logic start_ev, stop_ev, scl_rise, scl_fall;
    assign start_ev = sel_sy_r[1] & scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;  // [RL2] [RL20]
    assign stop_ev  = sel_sy_r[1] & scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;  // [RL3]
    assign scl_rise = scl_f_r & ~scl_d_r;
    assign scl_fall = ~scl_f_r & scl_d_r;

    st_e              st_r, st_nxt;
    logic [3:0]       bit_r, bit_nxt;
    logic [7:0]       sh_r, sh_nxt;
    logic [PTR_W-1:0] ptr_r, ptr_nxt;
    logic             rw_r, rw_nxt, busy_nxt;
    logic             drv_r, drv_nxt, out_r, out_nxt;
    logic             pend_r, pend_nxt, pval_r, pval_nxt;
    logic             adr_r, adr_nxt;
    logic [4:0]       hold_r, hold_nxt;
    logic             wr_en_nxt;
    logic [7:0]       wr_data_nxt;
    logic [PTR_W-1:0] wr_addr_nxt;

    always_comb begin
        st_nxt = st_r; bit_nxt = bit_r; sh_nxt = sh_r; ptr_nxt = ptr_r;
        rw_nxt = rw_r; busy_nxt = busy; pend_nxt = pend_r; pval_nxt = pval_r;
        drv_nxt = drv_r; out_nxt = out_r; hold_nxt = hold_r; adr_nxt = adr_r;
        wr_en_nxt = 1'b0; wr_data_nxt = wr_data; wr_addr_nxt = wr_addr;
        // Output changes wait out the hold after a falling clock [RL21]
        if (hold_r != 5'h0) begin
            hold_nxt = hold_r - 5'h1;
        end else if (pend_r) begin
            out_nxt  = pval_r;
            drv_nxt  = ~pval_r;
            pend_nxt = 1'b0;
        end
        if (!sel_sy_r[1]) begin
            st_nxt = S_IDLE; busy_nxt = 1'b0; drv_nxt = 1'b0; pend_nxt = 1'b0;  // [RL20]
        end else if (start_ev) begin
            st_nxt = S_DEV; bit_nxt = 4'h0; busy_nxt = 1'b1;  // [RL5]
            drv_nxt = 1'b0; pend_nxt = 1'b0;
        end else if (stop_ev) begin
            st_nxt = S_IDLE; busy_nxt = 1'b0; drv_nxt = 1'b0; pend_nxt = 1'b0;  // [RL5] [RL1]
        end else if (scl_rise) begin
            // Sample only at rising clock; data is stable while high [RL4]
            case (st_r)
                S_DEV, S_PTR, S_WDAT: begin
                    sh_nxt  = {sh_r[6:0], sda_f_r};
                    bit_nxt = bit_r + 4'h1;
                end
                S_RDAT: bit_nxt = bit_r + 4'h1;
                S_RACK: begin
                    if (sda_f_r) st_nxt = S_IDLE;  // Nack ends driving [RL16]
                    else         st_nxt = S_RDAT;  // [RL17]
                    bit_nxt = 4'h0;
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            hold_nxt = 5'(HOLD_CYCLES);
            pend_nxt = 1'b1;
            pval_nxt = 1'b1;  // Release by default [RL6]
            case (st_r)
                S_DEV: if (bit_r == 4'h8) begin
                    // General call (address 0) never matches [RL7] [RL22]
                    if (sh_r[7:1] == SLAVE_ADDR) begin
                        rw_nxt = sh_r[0]; st_nxt = S_ACK; pval_nxt = 1'b0;  // [RL10] [RL14]
                        adr_nxt = 1'b1;
                    end else begin
                        st_nxt = S_IDLE;
                    end
                end
                S_PTR, S_WDAT: if (bit_r == 4'h8) begin
                    st_nxt = S_ACK; pval_nxt = 1'b0;  // [RL10]
                    if (st_r == S_PTR) begin
                        ptr_nxt = sh_r[PTR_W-1:0];  // Reserved top bits ignored [RL9]
                    end else begin
                        wr_en_nxt   = 1'b1;  // [RL11]
                        wr_addr_nxt = ptr_r;
                        wr_data_nxt = sh_r;
                        ptr_nxt     = ptr_r + 1'b1;  // Natural wrap at 31 [RL12]
                    end
                end
                S_ACK: begin
                    bit_nxt = 4'h0;
                    adr_nxt = 1'b0;
                    if (rw_r) begin
                        st_nxt = S_RDAT; sh_nxt = rd_data; pval_nxt = rd_data[7];  // [RL15]
                    end else begin
                        // Byte after the address is the pointer [RL9]
                        st_nxt = adr_r ? S_PTR : S_WDAT;
                    end
                end
                S_RDAT: begin
                    if (bit_r == 4'h0) begin
                        // First fall after ack: load next register
                        sh_nxt = rd_data; pval_nxt = rd_data[7];
                    end else if (bit_r < 4'h8) begin
                        sh_nxt = {sh_r[6:0], 1'b1}; pval_nxt = sh_r[6];  // MSB first [RL15]
                    end else begin
                        ptr_nxt = ptr_r + 1'b1;  // [RL17]
                        st_nxt  = S_RACK;  // Release for master ack [RL6]
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= S_IDLE; bit_r <= 4'h0; sh_r <= 8'h00; ptr_r <= '0;
            rw_r <= 1'b0; busy <= 1'b0; drv_r <= 1'b0; out_r <= 1'b1;
            pend_r <= 1'b0; pval_r <= 1'b1; hold_r <= 5'h0; adr_r <= 1'b0;
            wr_en <= 1'b0; wr_data <= 8'h00; wr_addr <= '0;
            scl_d_r <= 1'b1; sda_d_r <= 1'b1;
        end else begin
            st_r <= st_nxt; bit_r <= bit_nxt; sh_r <= sh_nxt; ptr_r <= ptr_nxt;
            rw_r <= rw_nxt; busy <= busy_nxt; drv_r <= drv_nxt; out_r <= out_nxt;
            pend_r <= pend_nxt; pval_r <= pval_nxt; hold_r <= hold_nxt; adr_r <= adr_nxt;
            wr_en <= wr_en_nxt; wr_data <= wr_data_nxt; wr_addr <= wr_addr_nxt;
            scl_d_r <= scl_f_r; sda_d_r <= sda_f_r;
        end
    end

    // Open drain: only ever pulls low
    assign bus.sda_s_o  = 1'b0;
    assign bus.sda_s_oe = drv_r & ~out_r;
    assign rd_addr      = ptr_r;
endmodule : twi_slave

// ===== hdl/twi_master.sv
`timescale 1ns/1ns
module twi_master
    import twi_pkg::*;
(
    // System
    input  wire logic        clk,
    input  wire logic        rst,
    // Bus side
    twi_if.master            bus,
    // Command port: one byte per request
    input  wire logic        cmd_valid,
    input  wire logic        cmd_start,
    input  wire logic        cmd_stop,
    input  wire logic        cmd_read,
    input  wire logic        cmd_ack,
    input  wire logic [7:0]  cmd_data,
    output logic             cmd_ready,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_nack
);
    typedef enum logic [2:0] {
        M_IDLE = 3'b000, M_STA = 3'b001, M_BIT = 3'b011, M_STO = 3'b010, M_DONE = 3'b110
    } mst_e;

    logic [1:0]  sda_sy_r;
    mst_e        st_r, st_nxt;
    logic [6:0]  tick_r, tick_nxt;
    logic [1:0]  ph_r, ph_nxt;
    logic [3:0]  bit_r, bit_nxt;
    logic [8:0]  sh_r, sh_nxt;
    logic        stop_r, stop_nxt, rd_r, rd_nxt;
    logic        scl_r, scl_nxt, sda_r, sda_nxt;
    logic        rv_nxt, rn_nxt, rdy_nxt;
    logic [7:0]  rd_nxt_data;
    logic        tick;

    assign tick = (tick_r == 7'(HALF_BIT_CYCLES - 1));
    always_comb begin
        st_nxt = st_r; ph_nxt = ph_r; bit_nxt = bit_r; sh_nxt = sh_r;
        stop_nxt = stop_r; rd_nxt = rd_r; scl_nxt = scl_r; sda_nxt = sda_r;
        rv_nxt = 1'b0; rn_nxt = rsp_nack; rd_nxt_data = rsp_data; rdy_nxt = cmd_ready;
        tick_nxt = tick ? 7'h0 : tick_r + 7'h1;
        case (st_r)
            M_IDLE: if (cmd_valid && cmd_ready) begin
                rdy_nxt = 1'b0; stop_nxt = cmd_stop; rd_nxt = cmd_read;
                // Byte then ack slot; read releases data, acks per request [RL18]
                sh_nxt  = cmd_read ? {8'hFF, ~cmd_ack} : {cmd_data, 1'b1};
                bit_nxt = 4'h0; ph_nxt = 2'h0; tick_nxt = 7'h0;
                st_nxt  = cmd_start ? M_STA : M_BIT;
            end
            M_STA: if (tick) begin
                ph_nxt = ph_r + 2'h1;
                case (ph_r)
                    2'h0: begin sda_nxt = 1'b1; end
                    2'h1: begin scl_nxt = 1'b1; end
                    2'h2: begin sda_nxt = 1'b0; end  // Fall while clock high [RL2] [RL1]
                    default: begin scl_nxt = 1'b0; st_nxt = M_BIT; ph_nxt = 2'h0; end
                endcase
            end
            M_BIT: if (tick) begin
                ph_nxt = ph_r + 2'h1;
                case (ph_r)
                    2'h0: sda_nxt = sh_r[8];  // Change only while low [RL4] [RL8] [RL14]
                    2'h1: scl_nxt = 1'b1;
                    2'h2: begin
                        sh_nxt = {sh_r[7:0], sda_sy_r[1]};
                    end
                    default: begin
                        scl_nxt = 1'b0; ph_nxt = 2'h0; bit_nxt = bit_r + 4'h1;
                        if (bit_r == 4'h8) begin
                            st_nxt = stop_r ? M_STO : M_DONE;  // [RL13]
                        end
                    end
                endcase
            end
            M_STO: if (tick) begin
                ph_nxt = ph_r + 2'h1;
                case (ph_r)
                    2'h0: sda_nxt = 1'b0;
                    2'h1: scl_nxt = 1'b1;
                    2'h2: sda_nxt = 1'b1;  // Rise while clock high [RL3]
                    default: begin st_nxt = M_DONE; ph_nxt = 2'h0; end
                endcase
            end
            M_DONE: begin
                rv_nxt = 1'b1; rn_nxt = sh_r[0]; rd_nxt_data = sh_r[8:1];  // Ninth bit as sampled: slave ack on writes, own ack on reads [RL10]
                rdy_nxt = 1'b1; st_nxt = M_IDLE;
            end
            default: st_nxt = M_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sda_sy_r <= 2'h3; st_r <= M_IDLE; tick_r <= 7'h0; ph_r <= 2'h0;
            bit_r <= 4'h0; sh_r <= 9'h1FF; stop_r <= 1'b0; rd_r <= 1'b0;
            scl_r <= 1'b1; sda_r <= 1'b1; rsp_valid <= 1'b0; rsp_nack <= 1'b0;
            rsp_data <= 8'h00; cmd_ready <= 1'b1;
        end else begin
            sda_sy_r <= {sda_sy_r[0], bus.sda};
            st_r <= st_nxt; tick_r <= tick_nxt; ph_r <= ph_nxt; bit_r <= bit_nxt;
            sh_r <= sh_nxt; stop_r <= stop_nxt; rd_r <= rd_nxt;
            scl_r <= scl_nxt; sda_r <= sda_nxt; rsp_valid <= rv_nxt;
            rsp_nack <= rn_nxt; rsp_data <= rd_nxt_data; cmd_ready <= rdy_nxt;
        end
    end

    assign bus.scl_o    = 1'b0;
    assign bus.scl_oe   = ~scl_r;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = ~sda_r;
endmodule : twi_master

// ===== bench/twi_properties.sv
`timescale 1ns/1ns
module twi_properties
    import twi_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst,
    // Bus lines
    input wire logic scl_o,
    input wire logic scl_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda,
    // Mode select
    input wire logic twi_sel
);
    logic       scl_r, sda_r, busy_r, sel_r, rd_r;
    logic [3:0] bit_r;
    logic [1:0] byte_r;
    logic [6:0] sh_r;
    logic [4:0] hc_r;
    wire logic  pull  = sda_s_oe & ~sda_s_o;
    wire logic  rise  = scl & ~scl_r;
    wire logic  start = scl & scl_r & sda_r & ~sda;
    wire logic  stop  = scl & scl_r & ~sda_r & sda;
    wire logic  ninth = rise & (bit_r == 4'h8);
    // Slave owns the data line only in read data bytes
    wire logic  tx    = sel_r & rd_r & (byte_r != 2'h0);

    // Decode from raw wires, so filter lag of the slave is not modelled
    always_ff @(posedge clk) begin
        if (rst) begin
            {scl_r, sda_r, busy_r, sel_r, rd_r} <= 5'h18;
            {bit_r, byte_r, sh_r, hc_r}         <= '0;
        end else begin
            scl_r <= scl;
            sda_r <= sda;
            hc_r  <= (scl_r & ~scl) ? 5'h1 : ((hc_r != 5'h0 && hc_r < HOLD_CYCLES) ? hc_r + 5'h1 : 5'h0);
            if (start) begin
                {busy_r, sel_r, bit_r, byte_r} <= {2'b10, 6'h0};
            end else if (stop) begin
                busy_r <= 1'b0;
            end else if (rise && bit_r == 4'h8) begin
                bit_r  <= 4'h0;
                byte_r <= (byte_r == 2'h3) ? byte_r : byte_r + 2'h1;
            end else if (rise) begin
                sh_r  <= {sh_r[5:0], sda};
                bit_r <= bit_r + 4'h1;
                if (bit_r == 4'h7 && byte_r == 2'h0) begin
                    sel_r <= (sh_r == SLAVE_ADDR) && twi_sel;
                    rd_r  <= sda;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_stable_high; scl && scl_r |-> $stable(pull); endproperty
    a_stable_high: assert property (p_stable_high) else $error("slave data moved in clock high");
    property p_hold; hc_r != 5'h0 |-> $stable(pull); endproperty
    a_hold: assert property (p_hold) else $error("slave data hold too short");
    property p_idle; !busy_r |-> !pull; endproperty
    a_idle: assert property (p_idle) else $error("slave drives idle bus");
    property p_start_master; start |-> sda_m_oe && !sda_m_o; endproperty
    a_start_master: assert property (p_start_master) else $error("start not made by master");
    property p_addr_ack; ninth && byte_r == 2'h0 && sel_r |-> !sda; endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
    property p_addr_nack; ninth && byte_r == 2'h0 && !sel_r |-> sda; endproperty
    a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked");
    property p_write_ack; ninth && byte_r != 2'h0 && sel_r && !rd_r |-> !sda; endproperty
    a_write_ack: assert property (p_write_ack) else $error("written byte not acked");
    property p_read_release; ninth && tx |-> !pull; endproperty
    a_read_release: assert property (p_read_release) else $error("slave holds master ack slot");
    property p_rx_release; rise && bit_r < 4'h8 && !tx |-> !pull; endproperty
    a_rx_release: assert property (p_rx_release) else $error("slave drives master data bit");
endmodule : twi_properties

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import twi_pkg::*;
    logic       clk, rst, twi_sel, wr_en, busy, nk;
    logic       cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_ready, rsp_valid, rsp_nack;
    logic [7:0] cmd_data, rsp_data, wr_data, rd_data, q;
    logic [4:0] wr_addr, rd_addr;
    logic [7:0] regs [REG_COUNT];
    logic [7:0] wd [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    logic [7:0] bad [3] = '{{SLAVE_ADDR ^ 7'h01, 1'b0}, 8'h00, {SLAVE_ADDR, 1'b0}};
    int         mismatches, total_checks, i;

    twi_if bus_if ();
    twi_master twi_master_i (.clk(clk), .rst(rst), .bus(bus_if.master), .cmd_valid(cmd_valid),
        .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_ack(cmd_ack),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .rsp_nack(rsp_nack));
    twi_slave twi_slave_i (.clk(clk), .rst(rst), .bus(bus_if.slave), .twi_sel(twi_sel), .wr_en(wr_en),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
    twi_properties twi_properties_i (.clk(clk), .rst(rst), .scl_o(bus_if.scl_o), .scl_oe(bus_if.scl_oe),
        .sda_m_o(bus_if.sda_m_o), .sda_m_oe(bus_if.sda_m_oe), .sda_s_o(bus_if.sda_s_o),
        .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl), .sda(bus_if.sda), .twi_sel(twi_sel));

    // Register file beside the slave
    always @(posedge clk) if (wr_en) regs[wr_addr] <= wr_data;
    assign rd_data = regs[rd_addr];

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask : chk1

    // One byte on the bus; ready is seen at a falling edge, so the next rising edge takes it
    task automatic op(input logic s, input logic p, input logic r, input logic a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_data} = {1'b1, s, p, r, a, d};
        @(negedge clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 5000) begin
            mismatches++;
            $display("BAD %0t no response", $time);
        end
        q  = rsp_data;
        nk = rsp_nack;
    endtask : op

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        test_done();
    end

    initial begin
        {rst, twi_sel, cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_data} = {7'h60, 8'h00};
        for (i = 0; i < REG_COUNT; i++) regs[i] = 8'h00;
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        // Burst write from 30, reserved pointer bits set
        op(1, 0, 0, 0, {SLAVE_ADDR, 1'b0}); chk1(nk, 1'b0);
        chk1(busy, 1'b1);
        op(0, 0, 0, 0, 8'hFE); chk1(nk, 1'b0);
        for (i = 0; i < 4; i++) begin
            op(0, i == 3, 0, 0, wd[i]); chk1(nk, 1'b0);
        end
        repeat (20) @(negedge clk);
        chk1(busy, 1'b0);
        for (i = 0; i < 4; i++) chk8(regs[(30 + i) % 32], wd[i]);
        $display("test write_burst done");
        // Pointer set, repeated start, burst read across the wrap
        op(1, 0, 0, 0, {SLAVE_ADDR, 1'b0}); chk1(nk, 1'b0);
        op(0, 0, 0, 0, 8'h1F); chk1(nk, 1'b0);
        op(1, 0, 0, 0, {SLAVE_ADDR, 1'b1}); chk1(nk, 1'b0);
        for (i = 0; i < 3; i++) begin
            op(0, i == 2, 1, i != 2, 8'h00); chk8(q, wd[i + 1]);
        end
        $display("test read_burst done");
        // Foreign address, general call, port deselected
        for (i = 0; i < 3; i++) begin
            twi_sel = (i != 2);
            repeat (20) @(negedge clk);
            op(1, 0, 0, 0, bad[i]); chk1(nk, 1'b1);
            op(0, 1, 0, 0, 8'h03); chk1(nk, 1'b1);
        end
        chk8(regs[3], 8'h00);
        $display("test refusals done");
        test_done();
    end
endmodule : testbench
